// ==== design/acs_pkg.sv ====
// package: register map, field layout and conversion timing constants
package acs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // converter_control_status_a
  localparam logic [7:0] OFF_SEL = 8'h04; // channel_reference_select
  localparam logic [7:0] OFF_RES_LOW = 8'h08; // result_low_byte
  localparam logic [7:0] OFF_RES_HIGH = 8'h0C; // result_high_byte
  localparam logic [7:0] OFF_MODE = 8'h10; // mode bits
  localparam logic [7:0] OFF_STATUS = 8'h14; // sequencer status
  // control register fields
  localparam int B_ENABLE = 7; // converter_enable
  localparam int B_START = 6; // start_conversion
  localparam int B_AUTO = 5; // auto_trigger_enable
  localparam int B_DONE = 4; // conversion_done_flag, write one clears
  localparam int B_IRQ_EN = 3; // completion interrupt enable
  localparam int B_PS_LSB = 0; // prescaler_select, 3 bits
  // selection register fields
  localparam int B_CHAN_LSB = 0; // channel_select, 4 bits
  localparam int B_REF_LSB = 4; // reference_select, 3 bits
  // mode and status fields
  localparam int B_FREE_RUN = 0; // free running when auto triggered
  localparam int B_BUSY = 0; // conversion pending or running
  localparam int B_FIRST = 1; // next conversion is the long one
  // reset values
  localparam logic [2:0] RST_PS = 3'h0;
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [2:0] RST_REF = 3'h0;
  // conversion timing in converter clock cycles
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES = 25;
  localparam int NORMAL_SH_TENTHS = 15; // 1.5 cycles
  localparam int FIRST_SH_TENTHS = 135; // 13.5 cycles
  localparam int AUTO_SH_CYCLES = 2;
  localparam int AUTO_TOTAL_TENTHS = 135; // 13.5 cycles
  // the same figures as half-cycle counts of the converter clock
  localparam logic [5:0] NORMAL_END_HALF = 6'(2 * NORMAL_CYCLES);
  localparam logic [5:0] FIRST_END_HALF = 6'(2 * FIRST_CYCLES);
  localparam logic [5:0] AUTO_END_HALF = 6'(AUTO_TOTAL_TENTHS / 5);
  localparam logic [5:0] NORMAL_SH_HALF = 6'(NORMAL_SH_TENTHS / 5);
  localparam logic [5:0] FIRST_SH_HALF = 6'(FIRST_SH_TENTHS / 5);
  localparam logic [5:0] AUTO_SH_HALF = 6'(2 * AUTO_SH_CYCLES);
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} acs_state_t;
endpackage

// ==== design/acs_prescaler.sv ====
// converter clock prescaler: power-of-two divider with rise and fall ticks
`timescale 1ns/10ps
module acs_prescaler (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [2:0] sel,
  output logic rise,
  output logic fall
);
  logic [6:0] cnt_reg; // free running count of mclk
  wire [6:0] mask; // divisor minus one
  wire [6:0] phase; // position within one converter period

  // select 0 and 1 both divide by two, then 4 up to 128
  assign mask = (sel == 3'h0) ? 7'h01 : 7'((8'h01 << sel) - 8'h01);
  assign phase = cnt_reg & mask;
  assign rise = (phase == mask); // converter clock rising edge
  assign fall = (phase == (mask >> 1)); // converter clock falling edge

  // counter held at zero while cleared
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
    end else if (clear) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end
endmodule // acs_prescaler

// ==== design/acs_sync.sv ====
// two flip-flop synchroniser for inputs from outside the mclk domain
`timescale 1ns/10ps
module acs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by q

  // two stages, both cleared by reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // acs_sync

// ==== design/acs_top.sv ====
// converter sequencer: apb registers, start logic, timing and selection lock
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
// How it works
// - prescaler runs only while enable set
// - software start begins at next clock rise
// - conversion 13 cycles, 13.5 when triggered, first one 25
// - sample at 1.5 cycles, first 13.5
// - completion stores result, flags, clears start
// - trigger resets prescaler, samples two cycles later
// - free running restarts at once, start stays
// - selection buffered, locked during conversion
// - copying resumes in last converter cycle
// - free running reselection affects later conversions
// - quiet sleep with halted cpu starts conversion if irq enable set, auto trigger off
// - completion raises interrupt request when irq enable set
// - other sleep modes leave enable alone
// - start bit reads one while converting
// - trigger edges during conversion are ignored
// - low byte read blocks result updates
module acs_top
  import acs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_in,
  input wire logic cpu_halted,
  input wire logic quiet_sleep,
  input wire logic [9:0] core_result,
  output logic conv_clk_rise,
  output logic sample_hold,
  output logic conv_active,
  output logic [3:0] active_channel,
  output logic [2:0] active_reference,
  output logic conv_irq
);
  logic rst_meta_reg; // reset release, first stage
  logic rst_n_reg; // reset release, used by all logic
  logic enable_reg; // converter_enable
  logic start_reg; // start_conversion
  logic auto_reg; // auto_trigger_enable
  logic done_reg; // conversion_done_flag
  logic irq_en_reg; // completion interrupt enable
  logic [2:0] ps_reg; // prescaler_select
  logic free_run_reg; // free running mode
  logic [3:0] buf_chan_reg; // buffered channel_select
  logic [2:0] buf_ref_reg; // buffered reference_select
  logic [3:0] act_chan_reg; // active channel
  logic [2:0] act_ref_reg; // active reference
  logic [9:0] res_reg; // result registers
  logic res_lock_reg; // low byte read, high not yet
  logic first_reg; // next conversion is the first since enable
  logic trig_prev_reg; // trigger level one cycle ago
  logic halted_prev_reg; // cpu halt level one cycle ago
  logic [5:0] half_reg; // half cycles into the conversion
  logic [5:0] sh_pt_reg; // sample point in half cycles
  logic [5:0] end_pt_reg; // conversion length in half cycles
  logic sh_reg; // sample-and-hold pulse
  logic [31:0] prdata_reg; // read data captured in setup phase
  acs_state_t state_reg; // sequencer state
  logic trig_s; // synchronised trigger
  logic [9:0] core_s; // synchronised core result
  logic rise; // converter clock rising edge
  logic fall; // converter clock falling edge

  wire wr = psel & penable & pwrite; // write access phase
  wire rd = psel & penable & ~pwrite; // read access phase
  wire wr_ctrl = wr & (paddr == OFF_CTRL);
  wire wr_sel = wr & (paddr == OFF_SEL);
  wire wr_mode = wr & (paddr == OFF_MODE);
  wire rd_low = rd & (paddr == OFF_RES_LOW);
  wire rd_high = rd & (paddr == OFF_RES_HIGH);
  wire hit = (paddr == OFF_CTRL) | (paddr == OFF_SEL) |
             (paddr == OFF_RES_LOW) | (paddr == OFF_RES_HIGH) |
             (paddr == OFF_MODE) | (paddr == OFF_STATUS);
  wire half_tick = rise | fall; // any converter clock edge
  wire idle = (state_reg == ST_IDLE);
  wire trig_edge = trig_s & ~trig_prev_reg; // rising trigger edge
  wire free_mode = auto_reg & free_run_reg; // free running selected
  // trigger only from idle; edges while busy fall here
  wire trig_start = enable_reg & auto_reg & ~free_run_reg & idle &
                    trig_edge;
  // start bit written with enable held set
  wire sw_start = wr_ctrl & pwdata[B_START] & pwdata[B_ENABLE] & idle;
  // quiet sleep start once the cpu halts
  wire sleep_start = cpu_halted & ~halted_prev_reg & quiet_sleep &
                     enable_reg & idle & ~auto_reg & irq_en_reg;
  wire any_start = sw_start | sleep_start | trig_start;
  wire in_conv = (state_reg == ST_CONV);
  wire last_half = half_reg == (end_pt_reg - 6'h01);
  wire complete = in_conv & half_tick & last_half & enable_reg;
  wire restart = complete & free_mode; // back to back conversion
  // locked until the last converter cycle
  wire locked = in_conv & (half_reg < (end_pt_reg - 6'h02));
  // trigger starts count from the prescaler reset, so use auto timing
  wire [5:0] new_sh = first_reg ? FIRST_SH_HALF :
                      (trig_start ? AUTO_SH_HALF : NORMAL_SH_HALF);
  wire [5:0] new_end = first_reg ? FIRST_END_HALF :
                       (trig_start ? AUTO_END_HALF : NORMAL_END_HALF);
  wire [31:0] ctrl_word = {24'h000000, enable_reg, start_reg, auto_reg,
                           done_reg, irq_en_reg, ps_reg};
  wire [31:0] sel_word = {25'h0000000, buf_ref_reg, buf_chan_reg};
  wire [31:0] rd_word =
    (paddr == OFF_CTRL) ? ctrl_word :
    (paddr == OFF_SEL) ? sel_word :
    (paddr == OFF_RES_LOW) ? {24'h000000, res_reg[7:0]} :
    (paddr == OFF_RES_HIGH) ? {30'h00000000, res_reg[9:8]} :
    (paddr == OFF_MODE) ? {31'h00000000, free_run_reg} :
    (paddr == OFF_STATUS) ? {30'h00000000, first_reg, ~idle} :
    32'h00000000;

  // reset released through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // trigger pin synchroniser
  acs_sync #(.WIDTH(1)) u_trig_sync (
    .mclk(mclk),
    .rst_n(rst_n_reg),
    .d(trigger_in),
    .q(trig_s)
  );

  // analog core result synchroniser
  acs_sync #(.WIDTH(10)) u_res_sync (
    .mclk(mclk),
    .rst_n(rst_n_reg),
    .d(core_result),
    .q(core_s)
  );

  // prescaler cleared by disable or by a trigger
  acs_prescaler u_prescaler (
    .mclk(mclk),
    .rst_n(rst_n_reg),
    .clear(~enable_reg | trig_start),
    .sel(ps_reg),
    .rise(rise),
    .fall(fall)
  );

  // apb answer: one wait-free access phase
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_reg;
  assign conv_clk_rise = rise;
  assign sample_hold = sh_reg;
  assign conv_active = in_conv;
  assign active_channel = act_chan_reg;
  assign active_reference = act_ref_reg;
  // request raised while the flag stands and irq enable is set
  assign conv_irq = done_reg & irq_en_reg;

  // read data captured in the setup phase
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_reg <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_reg <= rd_word;
    end
  end

  // control register; sleep never touches enable
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      ps_reg <= RST_PS;
      free_run_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_reg <= pwdata[B_ENABLE];
        auto_reg <= pwdata[B_AUTO];
        irq_en_reg <= pwdata[B_IRQ_EN];
        ps_reg <= pwdata[B_PS_LSB +: 3];
      end
      if (wr_mode) begin
        free_run_reg <= pwdata[B_FREE_RUN];
      end
    end
  end

  // start bit: set by any start, held while busy
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      start_reg <= 1'b0;
    end else if (!enable_reg) begin
      start_reg <= 1'b0;
    end else if (any_start) begin
      start_reg <= 1'b1;
    end else if (complete & ~restart) begin
      start_reg <= 1'b0; // cleared with the flag
    end
  end

  // done flag: completion wins over a write-one clear
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      done_reg <= 1'b0;
    end else if (complete) begin
      done_reg <= 1'b1;
    end else if (wr_ctrl & pwdata[B_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // selection buffer written by software
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      buf_chan_reg <= RST_CHAN;
      buf_ref_reg <= RST_REF;
    end else if (wr_sel) begin
      buf_chan_reg <= pwdata[B_CHAN_LSB +: 4];
      buf_ref_reg <= pwdata[B_REF_LSB +: 3];
    end
  end

  // active selection follows buffer unless locked
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      act_chan_reg <= RST_CHAN;
      act_ref_reg <= RST_REF;
    end else if (!locked) begin
      act_chan_reg <= buf_chan_reg; // resumes near the end
      act_ref_reg <= buf_ref_reg;
    end
  end

  // result lock between low and high byte reads
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      res_reg <= 10'h000;
      res_lock_reg <= 1'b0;
    end else begin
      if (complete & ~res_lock_reg) begin
        res_reg <= core_s; // result stored at completion
      end
      if (rd_low) begin
        res_lock_reg <= 1'b1;
      end else if (rd_high) begin
        res_lock_reg <= 1'b0;
      end
    end
  end

  // first-conversion flag
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      first_reg <= 1'b1;
    end else if (!enable_reg) begin
      first_reg <= 1'b1;
    end else if (complete) begin
      first_reg <= 1'b0;
    end
  end

  // edge detector history
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      trig_prev_reg <= 1'b0;
      halted_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_s;
      halted_prev_reg <= cpu_halted;
    end
  end

  // sequencer state machine
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      half_reg <= 6'h00;
      sh_pt_reg <= NORMAL_SH_HALF;
      end_pt_reg <= NORMAL_END_HALF;
      sh_reg <= 1'b0;
    end else begin
      sh_reg <= in_conv & half_tick &
                (half_reg == (sh_pt_reg - 6'h01));
      if (!enable_reg) begin
        state_reg <= ST_IDLE;
        half_reg <= 6'h00;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (trig_start) begin
              state_reg <= ST_CONV; // trigger edge is the start
              half_reg <= 6'h00;
              sh_pt_reg <= new_sh;
              end_pt_reg <= new_end;
            end else if (any_start) begin
              state_reg <= ST_WAIT; // wait for the next rise
            end
          end
          ST_WAIT: begin
            if (rise) begin
              state_reg <= ST_CONV; // starts on the rise
              half_reg <= 6'h00;
              sh_pt_reg <= new_sh;
              end_pt_reg <= new_end;
            end
          end
          ST_CONV: begin
            if (restart) begin
              half_reg <= 6'h00; // next one at once
              sh_pt_reg <= NORMAL_SH_HALF;
              end_pt_reg <= NORMAL_END_HALF;
            end else if (complete) begin
              state_reg <= ST_IDLE;
              half_reg <= 6'h00;
            end else if (half_tick) begin
              half_reg <= half_reg + 6'h01; // length count
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // checks
  sequence s_wait_rise;
    (state_reg == ST_WAIT) && rise && enable_reg;
  endsequence
  sequence s_conv_begun;
    (state_reg == ST_CONV) && (half_reg == 6'h00);
  endsequence
  property p_presc_held;
    @(posedge mclk) disable iff (!rst_n_reg)
      (!enable_reg && !$past(enable_reg)) |-> !rise;
  endproperty
  a_presc_held: assert property (p_presc_held)
    else $error("converter clock ran while disabled");
  property p_start_on_rise;
    @(posedge mclk) disable iff (!rst_n_reg)
      s_wait_rise |=> s_conv_begun;
  endproperty
  a_start_on_rise: assert property (p_start_on_rise)
    else $error("conversion did not start on converter rise");
  property p_trig_start;
    @(posedge mclk) disable iff (!rst_n_reg)
      trig_start |=> s_conv_begun;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start conversion at once");
  property p_first_len;
    @(posedge mclk) disable iff (!rst_n_reg)
      (in_conv && first_reg) |-> (end_pt_reg == 6'd50);
  endproperty
  a_first_len: assert property (p_first_len)
    else $error("first conversion length wrong");
  property p_sample_point;
    @(posedge mclk) disable iff (!rst_n_reg)
      sh_reg |-> ($past(half_reg) == sh_pt_reg - 6'h01);
  endproperty
  a_sample_point: assert property (p_sample_point)
    else $error("sample pulse at wrong point");
  property p_complete_flags;
    @(posedge mclk) disable iff (!rst_n_reg)
      (complete && !restart) |=> (done_reg && !start_reg && idle);
  endproperty
  a_complete_flags: assert property (p_complete_flags)
    else $error("completion did not flag and clear start");
  property p_free_restart;
    @(posedge mclk) disable iff (!rst_n_reg)
      restart |=> (s_conv_begun and start_reg);
  endproperty
  a_free_restart: assert property (p_free_restart)
    else $error("free running did not restart");
  property p_sel_locked;
    @(posedge mclk) disable iff (!rst_n_reg)
      locked |=> $stable(act_chan_reg) && $stable(act_ref_reg);
  endproperty
  a_sel_locked: assert property (p_sel_locked)
    else $error("selection changed while locked");
  property p_res_blocked;
    @(posedge mclk) disable iff (!rst_n_reg)
      (complete && res_lock_reg) |=> ($stable(res_reg) && done_reg);
  endproperty
  a_res_blocked: assert property (p_res_blocked)
    else $error("locked result was overwritten");
  property p_busy_start;
    @(posedge mclk) disable iff (!rst_n_reg)
      (!idle && enable_reg) |-> start_reg;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("start bit low during conversion");
endmodule // acs_top

// ==== testbench/acs_core_model.sv ====
// analog core model: holds the sampled selection as its result
`timescale 1ns/10ps
module acs_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sample_hold,
  input wire logic [3:0] ch,
  input wire logic [2:0] rf,
  output logic [9:0] result
);
  // capture at the sample instant, held like a real s/h until next one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 10'h000;
    end else if (sample_hold) begin
      result <= {3'h5, rf, ch}; // code tells which selection was sampled
    end
  end
endmodule // acs_core_model

// ==== testbench/adc_conversion_sequencer_bench.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module adc_conversion_sequencer_bench
  import acs_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic trigger_in = 1'b0;
  logic cpu_halted = 1'b0;
  logic quiet_sleep = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] core_result;
  logic conv_clk_rise;
  logic sample_hold;
  logic conv_active;
  logic [3:0] active_channel;
  logic [2:0] active_reference;
  logic conv_irq;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] q; // last read data
  logic err; // last slave error
  int len; // mclk cycles of last conversion
  int sh; // sample offset in that conversion
  acs_top dut (.mclk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .trigger_in, .cpu_halted, .quiet_sleep,
    .core_result, .conv_clk_rise, .sample_hold, .conv_active,
    .active_channel, .active_reference, .conv_irq);
  acs_core_model core (.mclk, .rst_n(rstn), .sample_hold,
    .ch(active_channel), .rf(active_reference), .result(core_result));
  // clock, 25 ns
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input int w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    forever begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // measure the next conversion: length and sample offset
  task automatic conv();
    int n;
    n = 0;
    while (conv_active !== 1'b1 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 500) failures++; // no conversion began
    len = 0;
    sh = -1;
    while (conv_active === 1'b1 && len < 4000) begin
      if (sample_hold === 1'b1) sh = len;
      @(posedge mclk);
      len++;
    end
    if (len >= 4000) failures++; // conversion never ended
  endtask
  task automatic wait_sh();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sample_hold !== 1'b1 && n < 500);
    if (sample_hold !== 1'b1) failures++; // no sample pulse came
  endtask
  task automatic trig();
    @(posedge mclk);
    trigger_in <= 1'b1;
    repeat (4) @(posedge mclk);
    trigger_in <= 1'b0;
  endtask
  task automatic res(input logic [9:0] r);
    apb(0, OFF_RES_LOW, 0);
    chk(q, {24'h0, r[7:0]});
    apb(0, OFF_RES_HIGH, 0);
    chk(q, {30'h0, r[9:8]});
  endtask
  task automatic t_regs();
    apb(0, OFF_CTRL, 0);
    chk(q, 32'h0);
    apb(0, OFF_SEL, 0);
    chk(q, {25'h0, RST_REF, RST_CHAN});
    apb(0, 8'h18, 0);
    chk(q, 32'h0);
    chk(32'(err), 32'h1);
    repeat (20) begin
      @(posedge mclk);
      chk(32'(conv_clk_rise), 32'h0);
    end
    $display("test regs done");
  endtask
  task automatic t_first();
    apb(1, OFF_CTRL, 32'h80);
    apb(1, OFF_SEL, 32'h35);
    repeat (2) @(posedge mclk);
    chk(32'({active_reference, active_channel}), 32'h35);
    apb(1, OFF_CTRL, 32'hC0);
    fork
      conv();
      begin
        repeat (12) @(posedge mclk);
        apb(1, OFF_SEL, 32'h29);
        apb(0, OFF_CTRL, 0);
        chk(32'(q[6]), 32'h1);
        chk(32'(active_channel), 32'h5);
      end
    join
    chk(len, 32'd50);
    chk(sh, 32'd27);
    chk(32'(active_channel), 32'h9);
    apb(0, OFF_CTRL, 0);
    chk(q, 32'h90);
    res(10'h2B5);
    $display("test first done");
  endtask
  task automatic t_normal();
    apb(1, OFF_CTRL, 32'hD2);
    conv();
    chk(len, 32'd52);
    chk(sh, 32'd6);
    res(10'h2A9);
    apb(0, OFF_RES_LOW, 0);
    apb(1, OFF_SEL, 32'h07);
    apb(1, OFF_CTRL, 32'hD2);
    conv();
    apb(0, OFF_CTRL, 0);
    chk(q, 32'h92);
    res(10'h2A9);
    apb(1, OFF_CTRL, 32'hD2);
    conv();
    res(10'h287);
    $display("test normal done");
  endtask
  task automatic t_trig();
    apb(1, OFF_CTRL, 32'hB3);
    trig();
    conv();
    chk(len, 32'd108);
    chk(sh, 32'd16);
    trig();
    repeat (20) @(posedge mclk);
    trig();
    conv();
    repeat (60) @(posedge mclk);
    chk(32'(conv_active), 32'h0);
    $display("test trigger done");
  endtask
  task automatic t_free();
    apb(1, OFF_CTRL, 32'h10);
    apb(1, OFF_SEL, 32'h04);
    apb(1, OFF_MODE, 32'h1);
    apb(1, OFF_CTRL, 32'hA3); // enable first, start is gated by it
    apb(1, OFF_CTRL, 32'hE3);
    wait_sh();
    q = 0;
    for (int i = 0; i < 200 && q[4] !== 1'b1; i++) apb(0, OFF_CTRL, 0);
    chk(32'(q[4]), 32'h1);
    apb(1, OFF_SEL, 32'h06);
    wait_sh();
    chk(32'(active_channel), 32'h4);
    apb(0, OFF_CTRL, 0);
    chk(32'(q[6]), 32'h1);
    wait_sh();
    chk(32'(active_channel), 32'h6);
    apb(1, OFF_CTRL, 32'h10);
    apb(1, OFF_MODE, 32'h0);
    $display("test free done");
  endtask
  task automatic t_sleep();
    apb(1, OFF_SEL, 32'h11);
    // divide by 128: converter clock 312.5 kHz, kept under 1 MHz
    apb(1, OFF_CTRL, 32'h8F);
    @(posedge mclk);
    quiet_sleep <= 1'b1;
    cpu_halted <= 1'b1;
    conv();
    chk(len, 32'd3200);
    repeat (2) @(posedge mclk);
    chk(32'(conv_irq), 32'h1);
    apb(1, OFF_CTRL, 32'h9F);
    cpu_halted <= 1'b0;
    quiet_sleep <= 1'b0;
    @(posedge mclk);
    chk(32'(conv_irq), 32'h0);
    cpu_halted <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(32'(conv_active), 32'h0);
    apb(0, OFF_CTRL, 0);
    chk(q, 32'h8F);
    $display("test sleep done");
  endtask
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_first();
    t_normal();
    t_trig();
    t_free();
    t_sleep();
    finish_test();
  end
  // watchdog, well past the few thousand cycles the tests need
  initial begin
    #500000;
    failures++;
    finish_test();
  end
endmodule // adc_conversion_sequencer_bench
